// File: hw/irq_flag_pkg.sv
// Shared constants and types of the peripheral interrupt flag bank
package irq_flag_pkg;

	// ****************************************
	// Register port geometry
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int GROUPS = 4;
	localparam int CAPCMP_CH = 4;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] OFS_LOGIC_CELL_GATE = 12'h711;
	localparam logic [11:0] OFS_CAPTURE_COMPARE = 12'h712;
	localparam logic [11:0] OFS_MEM_OSC_WAVE = 12'h713;
	localparam logic [11:0] OFS_MEAS_TIMER = 12'h714;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h715;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h716;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h717;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_CELL2 = 5;
	localparam int BIT_CELL1 = 4;
	localparam int BIT_GATE5 = 2;
	localparam int BIT_GATE3 = 1;
	localparam int BIT_GATE1 = 0;
	localparam int BIT_CAPCMP_LSB = 0;
	localparam int BIT_MEM_DONE = 5;
	localparam int BIT_OSC_ROLL = 4;
	localparam int BIT_WAVE2 = 1;
	localparam int BIT_WAVE1 = 0;
	localparam int BIT_PULSE_W = 2;
	localparam int BIT_PERIOD = 1;
	localparam int BIT_MEAS = 0;
	localparam int ST_LOGIC_CELL_GATE = 0;
	localparam int ST_CAPTURE_COMPARE = 1;
	localparam int ST_MEM_OSC_WAVE = 2;
	localparam int ST_MEAS_TIMER = 3;

	// ****************************************
	// Implemented bits and reset values
	// ****************************************
	localparam logic [7:0] MASK_LOGIC_CELL_GATE = 8'h37;
	localparam logic [7:0] MASK_CAPTURE_COMPARE = 8'h0F;
	localparam logic [7:0] MASK_MEM_OSC_WAVE = 8'h33;
	localparam logic [7:0] MASK_MEAS_TIMER = 8'h07;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [3:0] RST_IRQ_STATUS = 4'h0;
	localparam logic [3:0] RST_IRQ_ENABLE = 4'h0;
	localparam logic [2:0] RST_GATE_LAST = 3'h0;
	localparam logic [1:0] RST_SHUT_LAST = 2'h0;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// ****************************************
	// Operating mode of a capture/compare channel
	// ****************************************
	typedef enum logic [2:0]
	{
		CAPCMP_CAPTURE = 3'b001,
		CAPCMP_COMPARE = 3'b010,
		CAPCMP_PWM = 3'b100
	} capcmp_mode_t;

endpackage : irq_flag_pkg

// File: hw/flag_port_if.sv
// Link between the top level and one sticky flag register
`timescale 1ns/1ns
interface flag_port_if;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] set;
	logic [7:0] q;

	// Top level drives writes and events, the register returns flags
	modport bank (input wr, input wdata, input set, output q);
	modport ctrl (output wr, output wdata, output set, input q);
endinterface : flag_port_if

// File: hw/sticky_flag_reg.sv
// One eight-bit flag register set by hardware and written by software
`timescale 1ns/1ns
module sticky_flag_reg
	import irq_flag_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Write, event and flag lines
	flag_port_if.bank port
);

	typedef struct packed
	{
		logic [7:0] flags;
	} flag_state_t;

	flag_state_t st_q;
	flag_state_t st_d;

	// Events are OR-ed in last so a write of zero never hides them
	always_comb
	begin
		st_d = st_q;
		if (port.wr)
		begin
			st_d.flags = (port.wdata | port.set) & MASK;
		end
		else
		begin
			st_d.flags = (st_q.flags | port.set) & MASK;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '{flags: RST_FLAGS};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign port.q = st_q.flags;

endmodule : sticky_flag_reg

// File: hw/irq_summary.sv
// Per-register event status, enable and the single interrupt line
`timescale 1ns/1ns
module irq_summary
	import irq_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Events, one per flag register
	input wire logic [3:0] evt,
	// Software access
	input wire logic clr_wr,
	input wire logic en_wr,
	input wire logic [3:0] wdata,
	// State seen by software and the CPU
	output logic [3:0] status,
	output logic [3:0] enable,
	output logic irq
);

	typedef struct packed
	{
		logic [3:0] stat;
		logic [3:0] en;
	} sum_state_t;

	sum_state_t st_q;
	sum_state_t st_d;

	// Ones written to the clear register drop status; new events win
	always_comb
	begin
		st_d = st_q;
		if (clr_wr)
		begin
			st_d.stat = st_q.stat & ~wdata;
		end
		st_d.stat = st_d.stat | evt;
		if (en_wr)
		begin
			st_d.en = wdata;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '{stat: RST_IRQ_STATUS, en: RST_IRQ_ENABLE};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign status = st_q.stat;
	assign enable = st_q.en;
	// Level output, AND-OR of the status and enable flops, not registered
	assign irq = |(st_q.stat & st_q.en);

endmodule : irq_summary

// File: hw/peripheral_irq_flag_bank.sv
// Peripheral interrupt request flag registers with register port
//
// Functional notes
// - Logic cell events set bits 5,4, sticky
// - Timer gate going inactive sets gate flag
// - Capture event sets channel flag, 0x712
// - Compare match sets channel flag, sticky
// - PWM trailing edge sets channel flag
// - Memory operation done sets 0x713 bit 5
// - Oscillator rollover sets 0x713 bit 4
// - Waveform shutdown entry sets its flag
// - Measurement timer flags at 0x714 bits 2..0
// - Flags set regardless of any enable
`timescale 1ns/1ns
module peripheral_irq_flag_bank
	import irq_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,

	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [DATA_W-1:0] rd_data,

	// Interrupt to the CPU
	output logic irq,

	// Logic cell interrupt conditions, one-cycle strobes
	input wire logic logic_cell2_output,
	input wire logic logic_cell1_output,

	// Timer gates, level, bit 0 timer 1, bit 1 timer 3, bit 2 timer 5
	input wire logic [2:0] timer_gate,

	// Capture/compare/PWM channels, index 0 is channel 1
	input wire capcmp_mode_t [CAPCMP_CH-1:0] capcmp_mode,
	input wire logic [CAPCMP_CH-1:0] capture_evt,
	input wire logic [CAPCMP_CH-1:0] compare_evt,
	input wire logic [CAPCMP_CH-1:0] pwm_trail_evt,

	// Memory and oscillator strobes
	input wire logic memory_op_done,
	input wire logic oscillator_rollover,

	// Waveform generator shutdown, level, bit 0 generator 1
	input wire logic [1:0] waveform_shutdown,

	// Measurement timer strobes
	input wire logic meas_pulse_width_evt,
	input wire logic meas_period_evt,
	input wire logic meas_timer_evt
);

	// ****************************************
	// Local state
	// ****************************************

	typedef struct packed
	{
		logic [2:0] gate_last;
		logic [1:0] shut_last;
		logic [7:0] rd_data;
	} bank_state_t;

	bank_state_t st_q;
	bank_state_t st_d;

	// ****************************************
	// Helpers
	// ****************************************

	// Only the event that belongs to the active mode counts
	function automatic logic capcmp_hit
	(
		input capcmp_mode_t mode,
		input logic cap,
		input logic cmp,
		input logic pwm
	);
		logic hit;
		hit = 1'b0;
		case (mode)
			CAPCMP_CAPTURE: hit = cap;
			CAPCMP_COMPARE: hit = cmp;
			CAPCMP_PWM: hit = pwm;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : capcmp_hit

	// Register select, used for both strobes
	function automatic logic hit_ofs
	(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		return a == ofs;
	endfunction : hit_ofs

	// ****************************************
	// Flag registers
	// ****************************************

	flag_port_if lcg_if ();
	flag_port_if cce_if ();
	flag_port_if mow_if ();
	flag_port_if mtf_if ();

	// Logic cell and timer gate flags
	sticky_flag_reg #(
		.MASK(MASK_LOGIC_CELL_GATE)
	) u_logic_cell_gate_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.port(lcg_if.bank)
	);

	// Capture/compare channel flags
	sticky_flag_reg #(
		.MASK(MASK_CAPTURE_COMPARE)
	) u_capture_compare_event_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.port(cce_if.bank)
	);

	// Memory, oscillator and waveform flags
	sticky_flag_reg #(
		.MASK(MASK_MEM_OSC_WAVE)
	) u_memory_oscillator_waveform_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.port(mow_if.bank)
	);

	// Measurement timer flags
	sticky_flag_reg #(
		.MASK(MASK_MEAS_TIMER)
	) u_measurement_timer_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.port(mtf_if.bank)
	);

	// ****************************************
	// Event detection
	// ****************************************

	logic [2:0] gate_fall;
	logic [1:0] shut_rise;
	logic [7:0] lcg_set;
	logic [7:0] cce_set;
	logic [7:0] mow_set;
	logic [7:0] mtf_set;

	// Gate end marks a finished acquisition, so watch the falling edge
	assign gate_fall = st_q.gate_last & ~timer_gate;
	// Only entry into shutdown counts, not the time spent there
	assign shut_rise = waveform_shutdown & ~st_q.shut_last;

	// Logic cell and gate events; enables play no part here
	always_comb
	begin
		lcg_set = 8'h00;
		lcg_set[BIT_CELL2] = logic_cell2_output;
		lcg_set[BIT_CELL1] = logic_cell1_output;
		lcg_set[BIT_GATE5] = gate_fall[2];
		lcg_set[BIT_GATE3] = gate_fall[1];
		lcg_set[BIT_GATE1] = gate_fall[0];
	end

	// Capture/compare events, one per channel
	always_comb
	begin
		cce_set = 8'h00;
		for (int i = 0; i < CAPCMP_CH; i++)
		begin
			cce_set[BIT_CAPCMP_LSB + i] = capcmp_hit(capcmp_mode[i],
				capture_evt[i], compare_evt[i], pwm_trail_evt[i]);
		end
	end

	// Memory, oscillator and waveform events
	always_comb
	begin
		mow_set = 8'h00;
		mow_set[BIT_MEM_DONE] = memory_op_done;
		mow_set[BIT_OSC_ROLL] = oscillator_rollover;
		mow_set[BIT_WAVE2] = shut_rise[1];
		mow_set[BIT_WAVE1] = shut_rise[0];
	end

	// Measurement timer events
	always_comb
	begin
		mtf_set = 8'h00;
		mtf_set[BIT_PULSE_W] = meas_pulse_width_evt;
		mtf_set[BIT_PERIOD] = meas_period_evt;
		mtf_set[BIT_MEAS] = meas_timer_evt;
	end

	// ****************************************
	// Register writes
	// ****************************************

	// Writes of zero clear flags inside the flag registers
	assign lcg_if.wr = wr_stb && hit_ofs(addr, OFS_LOGIC_CELL_GATE);
	assign cce_if.wr = wr_stb && hit_ofs(addr, OFS_CAPTURE_COMPARE);
	assign mow_if.wr = wr_stb && hit_ofs(addr, OFS_MEM_OSC_WAVE);
	assign mtf_if.wr = wr_stb && hit_ofs(addr, OFS_MEAS_TIMER);
	assign lcg_if.wdata = wr_data;
	assign cce_if.wdata = wr_data;
	assign mow_if.wdata = wr_data;
	assign mtf_if.wdata = wr_data;
	assign lcg_if.set = lcg_set;
	assign cce_if.set = cce_set;
	assign mow_if.set = mow_set;
	assign mtf_if.set = mtf_set;

	// ****************************************
	// Interrupt summary
	// ****************************************

	logic [3:0] grp_evt;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic irq_clr_wr;
	logic irq_en_wr;

	// Any new event of a register marks that register's status bit
	always_comb
	begin
		grp_evt = 4'h0;
		grp_evt[ST_LOGIC_CELL_GATE] = |lcg_set;
		grp_evt[ST_CAPTURE_COMPARE] = |cce_set;
		grp_evt[ST_MEM_OSC_WAVE] = |mow_set;
		grp_evt[ST_MEAS_TIMER] = |mtf_set;
	end

	assign irq_clr_wr = wr_stb && hit_ofs(addr, OFS_IRQ_CLEAR);
	assign irq_en_wr = wr_stb && hit_ofs(addr, OFS_IRQ_ENABLE);

	// Status is kept apart from the flags so clearing it leaves them
	irq_summary u_irq_summary (
		.clk_sys(clk_sys),
		.rst(rst),
		.evt(grp_evt),
		.clr_wr(irq_clr_wr),
		.en_wr(irq_en_wr),
		.wdata(wr_data[3:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq)
	);

	// ****************************************
	// Next state and read mux
	// ****************************************

	// Read data stands one cycle only; idle cycles read as zero
	always_comb
	begin
		st_d = st_q;
		st_d.gate_last = timer_gate;
		st_d.shut_last = waveform_shutdown;
		st_d.rd_data = 8'h00;
		if (!rd_stb)
		begin
			st_d.rd_data = 8'h00;
		end
		else if (hit_ofs(addr, OFS_LOGIC_CELL_GATE))
		begin
			st_d.rd_data = lcg_if.q;
		end
		else if (hit_ofs(addr, OFS_CAPTURE_COMPARE))
		begin
			st_d.rd_data = cce_if.q;
		end
		else if (hit_ofs(addr, OFS_MEM_OSC_WAVE))
		begin
			st_d.rd_data = mow_if.q;
		end
		else if (hit_ofs(addr, OFS_MEAS_TIMER))
		begin
			st_d.rd_data = mtf_if.q;
		end
		else if (hit_ofs(addr, OFS_IRQ_STATUS))
		begin
			st_d.rd_data = {4'h0, irq_status};
		end
		else if (hit_ofs(addr, OFS_IRQ_ENABLE))
		begin
			st_d.rd_data = {4'h0, irq_enable};
		end
		else
		begin
			st_d.rd_data = 8'h00;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '{gate_last: RST_GATE_LAST,
				shut_last: RST_SHUT_LAST,
				rd_data: RST_READ_DATA};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rd_data;

endmodule : peripheral_irq_flag_bank

// File: verification/irq_bank_chk_asserts.sv
// Port-level checks of the peripheral interrupt flag bank
`timescale 1ns/1ns
module irq_bank_chk
	import irq_flag_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rd_stb,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic irq,
	// Event lines
	input wire logic logic_cell2_output,
	input wire logic [2:0] timer_gate,
	input wire logic memory_op_done,
	input wire logic oscillator_rollover,
	input wire logic [1:0] waveform_shutdown,
	input wire logic meas_timer_evt
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Read decodes; a read right after an event must show it
	wire logic r_lcg = rd_stb && addr == OFS_LOGIC_CELL_GATE;
	wire logic r_mow = rd_stb && addr == OFS_MEM_OSC_WAVE;
	wire logic r_mt = rd_stb && addr == OFS_MEAS_TIMER;
	wire logic r_map = addr >= OFS_LOGIC_CELL_GATE && addr <= OFS_IRQ_ENABLE;

	// ****************************************
	// Assertions
	// ****************************************
	a_rd_idle_zero: assert property (!rd_stb |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_stb && !r_map |=> !rd_data)
		else $error("unmapped read not zero");
	a_unused_bits: assert property (r_lcg |=> !(rd_data & 8'hC8))
		else $error("unused flag bits not zero");
	a_cell_flag: assert property (
		logic_cell2_output ##1 r_lcg |=> rd_data[5])
		else $error("logic cell flag not set");
	a_gate_fall: assert property (
		$fell(timer_gate[0]) ##1 r_lcg |=> rd_data[0])
		else $error("gate flag not set");
	a_mem_flag: assert property (memory_op_done ##1 r_mow |=> rd_data[5])
		else $error("memory flag not set");
	a_osc_flag: assert property (
		oscillator_rollover ##1 r_mow |=> rd_data[4])
		else $error("rollover flag not set");
	a_wave_rise: assert property (
		$rose(waveform_shutdown[0]) ##1 r_mow |=> rd_data[0])
		else $error("shutdown flag not set");
	a_meas_flag: assert property (meas_timer_evt ##1 r_mt |=> rd_data[0])
		else $error("measurement flag not set");

	// Main scenarios reached
	c_mem_read: cover property (memory_op_done ##1 r_mow);
	c_gate_fall: cover property ($fell(timer_gate[0]));
	c_irq_rise: cover property ($rose(irq));
endmodule : irq_bank_chk

bind peripheral_irq_flag_bank irq_bank_chk u_irq_bank_chk (.clk_sys, .rst,
	.addr, .rd_stb, .rd_data, .irq, .logic_cell2_output, .timer_gate,
	.memory_op_done, .oscillator_rollover, .waveform_shutdown, .meas_timer_evt);

// File: verification/periph_event_model.sv
// Behavioural model of the peripherals that raise events
`timescale 1ns/1ns
module periph_event_model
	import irq_flag_pkg::*;
(
	// Clock, reset and bench requests
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [18:0] pulse_req,
	input wire logic [2:0] acq,
	input wire logic [1:0] shut,
	// Event lines to the flag bank
	output logic logic_cell2_output,
	output logic logic_cell1_output,
	output logic [2:0] timer_gate,
	output logic [3:0] capture_evt,
	output logic [3:0] compare_evt,
	output logic [3:0] pwm_trail_evt,
	output logic memory_op_done,
	output logic oscillator_rollover,
	output logic [1:0] waveform_shutdown,
	output logic meas_pulse_width_evt,
	output logic meas_period_evt,
	output logic meas_timer_evt
);
	typedef struct packed
	{
		logic [18:0] p;
		logic [2:0] g;
		logic [1:0] s;
	} model_state_t;
	model_state_t st_q;
	model_state_t st_d;

	// ****************************************
	// Requests are re-timed one cycle, like a real peripheral register
	// ****************************************
	always_comb
	begin
		st_d = '{p: pulse_req, g: acq, s: shut};
	end

	// Reset parks gates inactive and generators running
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Strobe layout: cell1, cell2, memory, rollover, timer, period, width
	assign logic_cell1_output = st_q.p[0];
	assign logic_cell2_output = st_q.p[1];
	assign memory_op_done = st_q.p[2];
	assign oscillator_rollover = st_q.p[3];
	assign meas_timer_evt = st_q.p[4];
	assign meas_period_evt = st_q.p[5];
	assign meas_pulse_width_evt = st_q.p[6];
	assign capture_evt = st_q.p[10:7];
	assign compare_evt = st_q.p[14:11];
	assign pwm_trail_evt = st_q.p[18:15];
	assign timer_gate = st_q.g;
	assign waveform_shutdown = st_q.s;
endmodule : periph_event_model

// File: verification/test_peripheral_irq_flag_bank.sv
// Self-checking bench of the peripheral interrupt flag bank
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module test_peripheral_irq_flag_bank
	import irq_flag_pkg::*;
	;
	logic clk_sys, rst, wr_stb, rd_stb, irq;
	logic [11:0] addr;
	logic [7:0] wr_data, rd_data;
	logic [18:0] pulse_req, r;
	logic [2:0] acq, timer_gate;
	logic [1:0] shut, waveform_shutdown;
	logic [3:0] capture_evt, compare_evt, pwm_trail_evt;
	logic logic_cell2_output, logic_cell1_output, memory_op_done;
	logic oscillator_rollover, meas_pulse_width_evt, meas_period_evt;
	logic meas_timer_evt;
	capcmp_mode_t [3:0] capcmp_mode;
	logic [19:0] m;
	int mismatches, n_checks;

	peripheral_irq_flag_bank u_peripheral_irq_flag_bank (.clk_sys, .rst,
		.addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .irq,
		.logic_cell2_output, .logic_cell1_output, .timer_gate, .capcmp_mode,
		.capture_evt, .compare_evt, .pwm_trail_evt, .memory_op_done,
		.oscillator_rollover, .waveform_shutdown, .meas_pulse_width_evt,
		.meas_period_evt, .meas_timer_evt);
	periph_event_model u_periph_event_model (.clk_sys, .rst, .pulse_req,
		.acq, .shut, .logic_cell2_output, .logic_cell1_output, .timer_gate,
		.capture_evt, .compare_evt, .pwm_trail_evt, .memory_op_done,
		.oscillator_rollover, .waveform_shutdown, .meas_pulse_width_evt,
		.meas_period_evt, .meas_timer_evt);

	// ****************************************
	// Bus tasks; each leaves one idle cycle, simpler than true back to back
	// ****************************************
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		wr_stb <= 1'b1;
		addr <= a;
		wr_data <= v;
		pulse_req <= '0;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input string n, input logic [11:0] a,
		input logic [7:0] e);
		@(posedge clk_sys);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#10;
		`CHK(n, e, rd_data)
	endtask : rd

	task automatic fire(input logic [18:0] v);
		@(posedge clk_sys);
		pulse_req <= v;
		@(posedge clk_sys);
		pulse_req <= '0;
	endtask : fire

	task automatic look(input string n, input logic e);
		@(posedge clk_sys);
		#10;
		`CHK(n, e, irq)
	endtask : look

	// Register and value set by each single strobe
	function automatic logic [19:0] evt_map(input int i);
		case (i)
			0: return {OFS_LOGIC_CELL_GATE, 8'h10};
			1: return {OFS_LOGIC_CELL_GATE, 8'h20};
			2: return {OFS_MEM_OSC_WAVE, 8'h20};
			3: return {OFS_MEM_OSC_WAVE, 8'h10};
			4: return {OFS_MEAS_TIMER, 8'h01};
			5: return {OFS_MEAS_TIMER, 8'h02};
			default: return {OFS_MEAS_TIMER, 8'h04};
		endcase
	endfunction : evt_map

	// Flag register and the bits it implements
	function automatic logic [19:0] impl_mask(input int j);
		case (j)
			0: return {OFS_LOGIC_CELL_GATE, MASK_LOGIC_CELL_GATE};
			1: return {OFS_CAPTURE_COMPARE, MASK_CAPTURE_COMPARE};
			2: return {OFS_MEM_OSC_WAVE, MASK_MEM_OSC_WAVE};
			default: return {OFS_MEAS_TIMER, MASK_MEAS_TIMER};
		endcase
	endfunction : impl_mask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// Free-running system clock, 100 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		report_and_stop;
	end

	// Main sequence
	initial
	begin
		{rst, wr_stb, rd_stb, addr, wr_data} = {3'b100, 20'h0_0000};
		{pulse_req, acq, shut, mismatches, n_checks} = '0;
		// Element by element, so no plain vector meets the enum
		for (int j = 0; j < 4; j++)
			capcmp_mode[j] = CAPCMP_CAPTURE;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 'h70F; a <= 'h719; a++)
			rd("reset or unmapped", a[11:0], 8'h00);
		// Writes of ones keep only the implemented bits
		for (int j = 0; j < 4; j++)
		begin
			m = impl_mask(j);
			wr(m[19:8], 8'hFF);
			rd("implemented bits", m[19:8], m[7:0]);
			wr(m[19:8], 8'h00);
		end
		// Single strobes with every enable off, then a clear by zero
		for (int i = 0; i < 7; i++)
		begin
			m = evt_map(i);
			fire(19'h1 << i);
			rd("event flag", m[19:8], m[7:0]);
			wr(m[19:8], 8'h00);
			rd("flag cleared", m[19:8], 8'h00);
		end
		// Only the event of the channel's own mode counts
		for (int k = 0; k < 3; k++)
		begin
			for (int j = 0; j < 4; j++)
				capcmp_mode[j] <= capcmp_mode_t'(3'b001 << k);
			for (int c = 0; c < 4; c++)
			begin
				r = 19'h1 << (7 + 4 * k + c);
				fire((19'h111 << (7 + c)) & ~r);
				rd("foreign mode", OFS_CAPTURE_COMPARE, 8'h00);
				fire(r);
				rd("channel", OFS_CAPTURE_COMPARE, 8'h01 << c);
				wr(OFS_CAPTURE_COMPARE, 8'h00);
			end
		end
		// A code outside the three modes lets no event through
		for (int j = 0; j < 4; j++)
			capcmp_mode[j] <= capcmp_mode_t'(3'b000);
		fire(19'h7_FF80);
		rd("no mode", OFS_CAPTURE_COMPARE, 8'h00);
		// Gate rise leaves flag clear, fall sets it
		for (int t = 0; t < 3; t++)
		begin
			acq <= 3'h1 << t;
			@(posedge clk_sys);
			rd("gate rise", OFS_LOGIC_CELL_GATE, 8'h00);
			acq <= 3'h0;
			@(posedge clk_sys);
			rd("gate fall", OFS_LOGIC_CELL_GATE, 8'h01 << t);
			wr(OFS_LOGIC_CELL_GATE, 8'h00);
		end
		// Shutdown entry sets; clearing holds while the level stays high
		for (int g = 0; g < 2; g++)
		begin
			shut <= 2'h1 << g;
			@(posedge clk_sys);
			rd("shutdown", OFS_MEM_OSC_WAVE, 8'h01 << g);
			wr(OFS_MEM_OSC_WAVE, 8'h00);
			rd("shutdown cleared", OFS_MEM_OSC_WAVE, 8'h00);
			shut <= 2'h0;
			@(posedge clk_sys);
		end
		rd("status", OFS_IRQ_STATUS, 8'h0F);
		wr(OFS_IRQ_STATUS, 8'h00);
		rd("status read only", OFS_IRQ_STATUS, 8'h0F);
		wr(OFS_IRQ_CLEAR, 8'h0F);
		rd("status cleared", OFS_IRQ_STATUS, 8'h00);
		wr(OFS_IRQ_ENABLE, 8'h04);
		rd("enable", OFS_IRQ_ENABLE, 8'h04);
		look("irq idle", 1'b0);
		// Memory event lands in the same cycle as a clearing write
		pulse_req <= 19'h4;
		wr(OFS_MEM_OSC_WAVE, 8'h00);
		rd("event beats clear", OFS_MEM_OSC_WAVE, 8'h20);
		look("irq raised", 1'b1);
		wr(OFS_IRQ_ENABLE, 8'h00);
		look("irq masked", 1'b0);
		wr(OFS_IRQ_ENABLE, 8'h04);
		look("irq unmasked", 1'b1);
		wr(OFS_IRQ_CLEAR, 8'h04);
		look("irq cleared", 1'b0);
		rd("flag kept", OFS_MEM_OSC_WAVE, 8'h20);
		report_and_stop;
	end
endmodule : test_peripheral_irq_flag_bank
